/* src/cmrd_ctrl.sv */
// common-mode and reference-drive control register with decoded switch outputs
// Behaviour
// [R01] five common-mode select bits, bits 23..19
// [R02] common mode averages selected electrodes
// [R03] select bit includes electrode; limbs set at reset
// [R04] external common mode overrides electrode selects
// [R05] none selected: use internal reference
// [R06] six summing bits 14..9, reset zero
// [R07] leg-drive off leaves summing switches alone
// [R08] bit 8 enables common-electrode reference
// [R09] four-bit field routes reference drive
// [R10] software avoids reserved drive codes
// [R11] bit 3 drives common mode pin
// [R12] external source blocks pin drive
// [R13] bit 2 external common mode, switches off
// [R14] bit 1 enables leg-drive reference electrode
// [R15] bit 0 enables shield drive
// [R16] reserved bits zero; outputs follow write together
`timescale 1ns/1ps
`default_nettype none
`include "cmrd_regs.svh"
module cmrd_ctrl
   import cmrd_pkg::*;
#(
   parameter int ADDR_W = `CMRD_ADDR_W
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic [4:0] o_cm_switch,
   output logic o_use_internal_ref,
   output logic o_cm_pin_drive,
   output logic [5:0] o_drive_sum,
   output logic o_ce_ref_enable,
   output logic [5:0] o_drive_target,
   output logic o_leg_drive_enable,
   output logic o_shield_drive_enable
);
   // reset image of the whole word, sliced per field below
   localparam logic [23:0] RST_WORD = `CMRD_CTRL_RESET;

   localparam logic [4:0] CM_SEL_RST = RST_WORD[`CMRD_CM_SEL_HI:`CMRD_CM_SEL_LO];
   localparam logic [5:0] SUM_RST = RST_WORD[`CMRD_SUM_HI:`CMRD_SUM_LO];
   localparam logic CE_REF_RST = RST_WORD[`CMRD_CE_REF_BIT];
   localparam logic [3:0] DRV_SEL_RST = RST_WORD[`CMRD_SEL_HI:`CMRD_SEL_LO];
   localparam logic PIN_DRV_RST = RST_WORD[`CMRD_PIN_DRV_BIT];
   localparam logic EXT_CM_RST = RST_WORD[`CMRD_EXT_CM_BIT];
   localparam logic LEG_EN_RST = RST_WORD[`CMRD_LEG_EN_BIT];
   localparam logic SHIELD_RST = RST_WORD[`CMRD_SHLD_BIT];
   localparam logic [ADDR_W-1:0] CTRL_IDX = ADDR_W'(`CMRD_OFS_CTRL);
   localparam logic [ADDR_W-1:0] STAT_IDX = ADDR_W'(`CMRD_OFS_STAT);

   // one register group per switch bank
   logic [4:0] cm_sel_q;
   logic [4:0] cm_sel_d;
   logic [5:0] sum_q;
   logic [5:0] sum_d;
   logic ce_ref_q;
   logic ce_ref_d;
   logic [3:0] drv_sel_q;
   logic [3:0] drv_sel_d;
   logic pin_drv_q;
   logic pin_drv_d;
   logic ext_cm_q;
   logic ext_cm_d;
   logic leg_en_q;
   logic leg_en_d;
   logic shield_q;
   logic shield_d;

   logic ctrl_wr;
   logic [23:0] wr_word;
   logic [23:0] ctrl_word;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // reserved bits never store, so they read zero [R16]
   function automatic logic [23:0] mask_reserved(
      input logic [23:0] word
   );
      logic [23:0] keep;
      keep = 24'hFFFFFF;
      keep[`CMRD_RSV_HI:`CMRD_RSV_LO] = 4'h0;
      return word & keep;
   endfunction : mask_reserved

   function automatic logic write_hit(
      input logic wr,
      input logic [ADDR_W-1:0] addr
   );
      return wr && (addr == CTRL_IDX);
   endfunction : write_hit

   function automatic logic [4:0] cm_sel_of(
      input logic [23:0] word
   );
      return word[`CMRD_CM_SEL_HI:`CMRD_CM_SEL_LO];
   endfunction : cm_sel_of

   function automatic logic [5:0] sum_of(
      input logic [23:0] word
   );
      return word[`CMRD_SUM_HI:`CMRD_SUM_LO];
   endfunction : sum_of

   function automatic logic [3:0] drv_sel_of(
      input logic [23:0] word
   );
      return word[`CMRD_SEL_HI:`CMRD_SEL_LO];
   endfunction : drv_sel_of

   // gathers the fields back into the software view
   function automatic logic [23:0] pack_ctrl(
      input logic [4:0] cm_sel,
      input logic [5:0] sum,
      input logic ce_ref,
      input logic [3:0] drv_sel,
      input logic pin_drv,
      input logic ext_cm,
      input logic leg_en,
      input logic shield
   );
      logic [23:0] word;
      word = 24'h000000;
      word[`CMRD_CM_SEL_HI:`CMRD_CM_SEL_LO] = cm_sel;
      word[`CMRD_SUM_HI:`CMRD_SUM_LO] = sum;
      word[`CMRD_CE_REF_BIT] = ce_ref;
      word[`CMRD_SEL_HI:`CMRD_SEL_LO] = drv_sel;
      word[`CMRD_PIN_DRV_BIT] = pin_drv;
      word[`CMRD_EXT_CM_BIT] = ext_cm;
      word[`CMRD_LEG_EN_BIT] = leg_en;
      word[`CMRD_SHLD_BIT] = shield;
      return word;
   endfunction : pack_ctrl

   // live decoded state for software
   function automatic logic [31:0] pack_status(
      input logic sel_bad,
      input logic int_ref,
      input logic pin_drv,
      input logic [4:0] cm_sw,
      input logic [5:0] target
   );
      logic [31:0] word;
      word = 32'h00000000;
      word[`CMRD_STAT_BAD_BIT] = sel_bad;
      word[`CMRD_STAT_INT_BIT] = int_ref;
      word[`CMRD_STAT_PIN_BIT] = pin_drv;
      word[`CMRD_STAT_CM_HI:`CMRD_STAT_CM_LO] = cm_sw;
      word[`CMRD_STAT_TGT_HI:`CMRD_STAT_TGT_LO] = target;
      return word;
   endfunction : pack_status

   // decode stays combinational so outputs move with the register
   cmrd_sw_if sw ();

   cmrd_decode u_decode (
      .sw(sw)
   );

   assign ctrl_wr = write_hit(i_wr, i_addr);
   assign wr_word = mask_reserved(i_wdata[23:0]);
   assign ctrl_word = pack_ctrl(cm_sel_q, sum_q, ce_ref_q, drv_sel_q, pin_drv_q, ext_cm_q,
      leg_en_q, shield_q);
   assign sw.ctrl = ctrl_word;

   // write path: each field group loads only on a control write
   always_comb begin
      if (ctrl_wr) begin
         cm_sel_d = cm_sel_of(wr_word); // [R01] [R03]
      end else begin
         cm_sel_d = cm_sel_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cm_sel_q <= CM_SEL_RST; // [R03]
      end else begin
         cm_sel_q <= cm_sel_d;
      end
   end

   // summing switches ignore leg-drive enable and route field [R07]
   always_comb begin
      if (ctrl_wr) begin
         sum_d = sum_of(wr_word); // [R06]
      end else begin
         sum_d = sum_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sum_q <= SUM_RST; // [R06]
      end else begin
         sum_q <= sum_d;
      end
   end

   always_comb begin
      if (ctrl_wr) begin
         ce_ref_d = wr_word[`CMRD_CE_REF_BIT]; // [R08]
      end else begin
         ce_ref_d = ce_ref_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ce_ref_q <= CE_REF_RST; // [R08]
      end else begin
         ce_ref_q <= ce_ref_d;
      end
   end

   always_comb begin
      if (ctrl_wr) begin
         drv_sel_d = drv_sel_of(wr_word); // [R09]
      end else begin
         drv_sel_d = drv_sel_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         drv_sel_q <= DRV_SEL_RST; // [R09]
      end else begin
         drv_sel_q <= drv_sel_d;
      end
   end

   always_comb begin
      if (ctrl_wr) begin
         pin_drv_d = wr_word[`CMRD_PIN_DRV_BIT]; // [R11]
      end else begin
         pin_drv_d = pin_drv_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_drv_q <= PIN_DRV_RST; // [R11]
      end else begin
         pin_drv_q <= pin_drv_d;
      end
   end

   always_comb begin
      if (ctrl_wr) begin
         ext_cm_d = wr_word[`CMRD_EXT_CM_BIT]; // [R13]
      end else begin
         ext_cm_d = ext_cm_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ext_cm_q <= EXT_CM_RST; // [R13]
      end else begin
         ext_cm_q <= ext_cm_d;
      end
   end

   always_comb begin
      if (ctrl_wr) begin
         leg_en_d = wr_word[`CMRD_LEG_EN_BIT]; // [R14]
      end else begin
         leg_en_d = leg_en_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         leg_en_q <= LEG_EN_RST; // [R14]
      end else begin
         leg_en_q <= leg_en_d;
      end
   end

   always_comb begin
      if (ctrl_wr) begin
         shield_d = wr_word[`CMRD_SHLD_BIT]; // [R15]
      end else begin
         shield_d = shield_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         shield_q <= SHIELD_RST; // [R15]
      end else begin
         shield_q <= shield_d;
      end
   end

   // read data stands one cycle after the strobe, zero otherwise
   always_comb begin
      rdata_d = 32'h00000000;
      if (i_rd) begin
         unique case (i_addr)
            CTRL_IDX: rdata_d = {8'h00, ctrl_word}; // [R16]
            STAT_IDX: rdata_d = pack_status(sw.select_bad, sw.use_internal_ref,
               sw.cm_pin_drive, sw.cm_switch, sw.drive_target);
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign o_rdata = rdata_q;

   // all switch controls derive from the one register, so they change together [R16]
   assign o_cm_switch = sw.cm_switch; // [R02] analog averaging of closed switches
   assign o_use_internal_ref = sw.use_internal_ref; // [R05]
   assign o_cm_pin_drive = sw.cm_pin_drive; // [R11] [R12]
   assign o_drive_sum = sum_q; // [R06] [R07]
   assign o_ce_ref_enable = ce_ref_q; // [R08]
   assign o_drive_target = sw.drive_target; // [R09]
   assign o_leg_drive_enable = leg_en_q; // [R14]
   assign o_shield_drive_enable = shield_q; // [R15]
endmodule : cmrd_ctrl
`default_nettype wire

/* src/cmrd_regs.svh */
// register offsets, field positions and reset values of the common-mode control bank
`ifndef CMRD_REGS_SVH
`define CMRD_REGS_SVH
`define CMRD_ADDR_W 4
`define CMRD_OFS_CTRL 4'h0
`define CMRD_OFS_STAT 4'h1
`define CMRD_CM_SEL_HI 23
`define CMRD_CM_SEL_LO 19
`define CMRD_RSV_HI 18
`define CMRD_RSV_LO 15
`define CMRD_SUM_HI 14
`define CMRD_SUM_LO 9
`define CMRD_CE_REF_BIT 8
`define CMRD_SEL_HI 7
`define CMRD_SEL_LO 4
`define CMRD_PIN_DRV_BIT 3
`define CMRD_EXT_CM_BIT 2
`define CMRD_LEG_EN_BIT 1
`define CMRD_SHLD_BIT 0
`define CMRD_CTRL_RESET 24'hE00000
`define CMRD_SEL_LAST 4'h5
`define CMRD_STAT_BAD_BIT 14
`define CMRD_STAT_INT_BIT 13
`define CMRD_STAT_PIN_BIT 12
`define CMRD_STAT_CM_HI 11
`define CMRD_STAT_CM_LO 7
`define CMRD_STAT_TGT_HI 5
`define CMRD_STAT_TGT_LO 0
`endif

/* src/cmrd_pkg.sv */
// types shared by the common-mode control bank
package cmrd_pkg;
   typedef enum logic [3:0] {
      CMRD_DRV_OUT = 4'h0,
      CMRD_DRV_LEFT_ARM = 4'h1,
      CMRD_DRV_LEFT_LEG = 4'h2,
      CMRD_DRV_RIGHT_ARM = 4'h3,
      CMRD_DRV_CHEST_ONE = 4'h4,
      CMRD_DRV_CHEST_TWO = 4'h5
   } cmrd_drive_e;
endpackage : cmrd_pkg

/* src/cmrd_sw_if.sv */
// carrier for decoded switch controls between bank and decoder
`timescale 1ns/1ps
`default_nettype none
interface cmrd_sw_if;
   logic [23:0] ctrl;
   logic [4:0] cm_switch;
   logic use_internal_ref;
   logic cm_pin_drive;
   logic [5:0] drive_target;
   logic select_bad;
   modport bank (output ctrl, input cm_switch, use_internal_ref, cm_pin_drive, drive_target,
      select_bad);
   modport dec (input ctrl, output cm_switch, use_internal_ref, cm_pin_drive, drive_target,
      select_bad);
endinterface : cmrd_sw_if
`default_nettype wire

/* src/cmrd_decode.sv */
// combinational decode of the control word into switch enables
`timescale 1ns/1ps
`default_nettype none
`include "cmrd_regs.svh"
module cmrd_decode
   import cmrd_pkg::*;
(
   cmrd_sw_if.dec sw
);
   logic ext_cm;
   logic [3:0] sel;

   assign ext_cm = sw.ctrl[`CMRD_EXT_CM_BIT];
   assign sel = sw.ctrl[`CMRD_SEL_HI:`CMRD_SEL_LO];

   always_comb begin
      // external source opens every common-mode electrode switch [R04] [R13]
      sw.cm_switch = ext_cm ? 5'h00 : sw.ctrl[`CMRD_CM_SEL_HI:`CMRD_CM_SEL_LO]; // [R01] [R03]
      // nothing picked: fall back to the internal reference [R05]
      sw.use_internal_ref = !ext_cm && (sw.ctrl[`CMRD_CM_SEL_HI:`CMRD_CM_SEL_LO] == 5'h00);
      sw.cm_pin_drive = sw.ctrl[`CMRD_PIN_DRV_BIT] && !ext_cm; // [R11] [R12]
      sw.drive_target = 6'h00;
      sw.select_bad = 1'b0;
      unique case (sel)
         CMRD_DRV_OUT: sw.drive_target = 6'h01; // [R09]
         CMRD_DRV_LEFT_ARM: sw.drive_target = 6'h02;
         CMRD_DRV_LEFT_LEG: sw.drive_target = 6'h04;
         CMRD_DRV_RIGHT_ARM: sw.drive_target = 6'h08;
         CMRD_DRV_CHEST_ONE: sw.drive_target = 6'h10;
         CMRD_DRV_CHEST_TWO: sw.drive_target = 6'h20;
         // reserved codes route nowhere, flagged for software [R10]
         default: sw.select_bad = 1'b1;
      endcase
   end
endmodule : cmrd_decode
`default_nettype wire

/* sim/cmrd_ctrl_assertions.sv */
// bank checker
`timescale 1ns/1ps
`default_nettype none
module cmrd_ctrl_chk #(parameter int ADDR_W = 4) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic o_use_internal_ref,
   input wire logic o_cm_pin_drive,
   input wire logic o_ce_ref_enable,
   input wire logic o_leg_drive_enable,
   input wire logic o_shield_drive_enable,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic [31:0] o_rdata,
   input wire logic [4:0] o_cm_switch,
   input wire logic [5:0] o_drive_sum,
   input wire logic [5:0] o_drive_target
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire logic w = i_wr && i_addr == '0;
   logic [23:0] v_q;
   always_ff @(posedge i_clk) v_q <= i_wdata[23:0];
   property p_ext; w && i_wdata[2] |=> o_cm_switch == 5'h00; endproperty
   a_ext: assert property (p_ext) else $error("ext");
   property p_cm; w && !i_wdata[2] |=> o_cm_switch == v_q[23:19]; endproperty
   a_cm: assert property (p_cm) else $error("cm");
   property p_ref; w |=> o_use_internal_ref == (v_q[23:19] == 5'h00 && !v_q[2]); endproperty
   a_ref: assert property (p_ref) else $error("ref");
   property p_pin; w |=> o_cm_pin_drive == (v_q[3] && !v_q[2]); endproperty
   a_pin: assert property (p_pin) else $error("pin");
   property p_sum; w |=> o_drive_sum == v_q[14:9]; endproperty
   a_sum: assert property (p_sum) else $error("sum");
   property p_tgt; w && i_wdata[7:4] < 4'h6 |=> o_drive_target == 6'h01 << v_q[7:4]; endproperty
   a_tgt: assert property (p_tgt) else $error("tgt");
   property p_rd; i_rd |=> o_rdata[31:24] == 8'h00 && o_rdata[18:15] == 4'h0; endproperty
   a_rd: assert property (p_rd) else $error("rsv");
   property p_hold; !w |=> $stable(o_cm_switch) && $stable(o_drive_sum); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_ce; w |=> o_ce_ref_enable == v_q[8]; endproperty
   a_ce: assert property (p_ce) else $error("ce ref");
   property p_leg; w |=> o_leg_drive_enable == v_q[1]; endproperty
   a_leg: assert property (p_leg) else $error("leg");
   property p_shd; w |=> o_shield_drive_enable == v_q[0]; endproperty
   a_shd: assert property (p_shd) else $error("shield");
   cover property (w && i_wdata[2]);
   cover property (w && i_wdata[7:4] == 4'h5);
   cover property (i_rd && i_addr != '0);
endmodule : cmrd_ctrl_chk
bind cmrd_ctrl cmrd_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (
   .i_clk(i_clk),
   .i_rst(i_rst),
   .i_wr(i_wr),
   .i_rd(i_rd),
   .o_use_internal_ref(o_use_internal_ref),
   .o_cm_pin_drive(o_cm_pin_drive),
   .o_ce_ref_enable(o_ce_ref_enable),
   .o_leg_drive_enable(o_leg_drive_enable),
   .o_shield_drive_enable(o_shield_drive_enable),
   .i_addr(i_addr),
   .i_wdata(i_wdata),
   .o_rdata(o_rdata),
   .o_cm_switch(o_cm_switch),
   .o_drive_sum(o_drive_sum),
   .o_drive_target(o_drive_target)
);
`default_nettype wire

/* sim/common_mode_reference_drive_ctl_test.sv */
// bank test
`timescale 1ns/1ps
`default_nettype none
module common_mode_reference_drive_ctl_test;
   logic i_clk = 1'b0;
   logic i_rst, i_wr, i_rd, o_use_internal_ref, o_cm_pin_drive, o_ce_ref_enable;
   logic o_leg_drive_enable, o_shield_drive_enable;
   logic [3:0] i_addr;
   logic [4:0] o_cm_switch;
   logic [5:0] o_drive_sum, o_drive_target;
   logic [31:0] i_wdata, o_rdata, d;
   int err_count, n_tests;
   cmrd_ctrl uut (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .i_wr(i_wr),
      .i_rd(i_rd),
      .o_rdata(o_rdata),
      .o_cm_switch(o_cm_switch),
      .o_use_internal_ref(o_use_internal_ref),
      .o_cm_pin_drive(o_cm_pin_drive),
      .o_drive_sum(o_drive_sum),
      .o_ce_ref_enable(o_ce_ref_enable),
      .o_drive_target(o_drive_target),
      .o_leg_drive_enable(o_leg_drive_enable),
      .o_shield_drive_enable(o_shield_drive_enable)
   );
   initial forever #5 i_clk = ~i_clk;
   // stored image of a written word: upper byte and reserved bits drop
   function automatic logic [31:0] exp_ctrl(input logic [31:0] v);
      return v & 32'h00F87FFF;
   endfunction : exp_ctrl
   // status word worked out from a stored control image
   function automatic logic [31:0] exp_stat(input logic [31:0] c);
      logic ext;
      logic [4:0] cm;
      ext = c[2];
      cm = ext ? 5'h00 : c[23:19];
      return {17'h00000, c[7:4] > 4'h5, !ext && c[23:19] == 5'h00, c[3] && !ext, cm, 1'b0,
         6'(c[7:4] > 4'h5 ? 0 : 1 << c[7:4])};
   endfunction : exp_stat
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s exp %h got %h", name, exp, got);
      end
   endtask : check
   task chk_out(input logic [31:0] c);
      logic [31:0] s;
      s = exp_stat(c);
      check("cm_switch", 32'(s[11:7]), 32'(o_cm_switch));
      check("internal_ref", 32'(s[13]), 32'(o_use_internal_ref));
      check("pin_drive", 32'(s[12]), 32'(o_cm_pin_drive));
      check("drive_sum", 32'(c[14:9]), 32'(o_drive_sum));
      check("ce_ref", 32'(c[8]), 32'(o_ce_ref_enable));
      check("target", 32'(s[5:0]), 32'(o_drive_target));
      check("leg_enable", 32'(c[1]), 32'(o_leg_drive_enable));
      check("shield", 32'(c[0]), 32'(o_shield_drive_enable));
   endtask : chk_out
   // on a read, v is the expected read data
   task op(input logic w, input logic [3:0] a, input logic [31:0] v);
      @(posedge i_clk);
      {i_wr, i_rd, i_addr, i_wdata} <= {w, !w, a, v};
      @(posedge i_clk);
      {i_wr, i_rd} <= 2'h0;
      #1;
      if (!w) check("rdata", v, o_rdata);
   endtask : op
   task conclude;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (999) @(posedge i_clk);
      err_count++;
      conclude();
   end
   initial begin
      {i_rst, i_wr, i_rd, i_addr, i_wdata} = {3'h4, 36'h0};
      d = $urandom(32'hFC82);
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      chk_out(32'h00E00000);
      op(1'b0, 4'h0, 32'h00E00000);
      op(1'b0, 4'h1, exp_stat(32'h00E00000));
      $display("test reset end");
      // every legal drive code; every fourth word selects no electrode
      for (int i = 0; i < 48; i++) begin
         d = $urandom & (i[1:0] ? 32'hFFFFFF0F : 32'hFF07FF0B) | 32'(i % 6) << 4;
         op(1'b1, 4'h0, d);
         chk_out(exp_ctrl(d));
         op(1'b0, i[4] ? 4'h1 : 4'h0, i[4] ? exp_stat(exp_ctrl(d)) : exp_ctrl(d));
         if (i[3:0] == 4'h7) op(1'b0, 4'h9, 32'h0);
      end
      op(1'b1, 4'h1, 32'h00FFFFFF);
      op(1'b0, 4'h0, exp_ctrl(d));
      $display("test random end");
      conclude();
   end
endmodule : common_mode_reference_drive_ctl_test
`default_nettype wire
